// [imfc_host_model.sv]
// host master model for the two-wire bus: makes scl and pulls data low
// assumes the bench resolves the pulled-up data wire and calls tasks at falling clk edges
`timescale 1ns/1ps
module imfc_host_model (
  input  wire logic clk,       // system clock, sets bit timing
  input  wire logic sda_line,  // resolved data wire level
  output logic      scl,       // bus clock, driven by master only
  output logic      sda_low    // high pulls data low, else released
);
  localparam int Q = 4;  // quarter bit in clk cycles, slow enough for 3-clk answer delay
  // ************************************************************
  // bus idles with both lines high
  // ************************************************************
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // start is only issued from idle, so scl is already high here
  task automatic start;
    sda_low = 1'b1;
    repeat (Q) @(negedge clk);
  endtask : start
  // one clock pulse; data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    repeat (Q) @(negedge clk);
    sda_low = ~b;
    repeat (Q) @(negedge clk);
    scl = 1'b1;
    repeat (Q) @(negedge clk);
    s = sda_line;
    repeat (Q) @(negedge clk);
  endtask : bit_io
  // eight bits msb first, then data released for the slave's ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wbyte
  // eight bits read, then ack low unless this is the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rbyte
  // data rises while scl high; ends every transfer
  task automatic stop;
    scl = 1'b0;
    repeat (Q) @(negedge clk);
    sda_low = 1'b1;
    repeat (Q) @(negedge clk);
    scl = 1'b1;
    repeat (Q) @(negedge clk);
    sda_low = 1'b0;
    repeat (Q) @(negedge clk);
  endtask : stop
endmodule : imfc_host_model

// [imfc_pkg.sv]
// constants, field positions and state encodings for the two-wire switch slave
// assumes one 25 MHz system clock; all bus pins arrive asynchronously
// Operation
// - capture first two bytes after each START
// - freeze capture on bus lock-up
// - reading second capture register unfreezes it
// - stuck-high bit n blocks channel n
// - fault interrupt needs irq and preconnect enables
// - reading fault register clears it, releases pin
// - preconnect test runs on each new selection
// - long host low on pin resets all but the capture registers
// - own interrupt drive never seen as reset
// - lock-up interrupt only when irq enabled
// - release by read or after timeout
// - new lock-up asserts interrupt again
// - driven interrupt never resets device
// - slave only, scl input, sda open drain
// - start, address, direction, data, stop
// - start and stop are sda edges, scl high
// - data sampled while scl high
// - nine clocks per byte, receiver acknowledges
// - pointer restarts at zero, increments per byte
// - writes cycle through registers zero to two
// - reads cycle through all seven registers
// - basic mode always targets channel select
// - register map zero to six
// - reading lock-up register releases interrupt only when read release is selected, not timed release
package imfc_pkg;
  localparam logic [2:0] IMFC_REG_CHAN   = 3'h0;
  localparam logic [2:0] IMFC_REG_CONFIG = 3'h1;
  localparam logic [2:0] IMFC_REG_FLUSH  = 3'h2;
  localparam logic [2:0] IMFC_REG_LOCKUP = 3'h3;
  localparam logic [2:0] IMFC_REG_CAP0   = 3'h4;
  localparam logic [2:0] IMFC_REG_CAP1   = 3'h5;
  localparam logic [2:0] IMFC_REG_FAULT  = 3'h6;
  localparam logic [2:0] IMFC_LAST_WR    = 3'h2;
  localparam logic [2:0] IMFC_LAST_RD    = 3'h6;
  // configuration field positions
  localparam int IMFC_IRQ_ENABLE_BIT      = 0;
  localparam int IMFC_IRQ_RELEASE_SEL_BIT = 2;
  localparam int IMFC_BASIC_MODE_BIT      = 6;
  localparam int IMFC_PRECONNECT_TEST_BIT = 7;
  // reset values
  localparam logic [7:0] IMFC_CHAN_RST   = 8'h00;
  localparam logic [7:0] IMFC_CONFIG_RST = 8'h00;
  localparam logic [7:0] IMFC_FLUSH_RST  = 8'hFF;
  // timing
  localparam int IMFC_CLK_HZ             = 25_000_000;
  localparam int IMFC_RESET_PULSE_MIN_NS = 500;
  localparam int IMFC_RESET_CYC          = (IMFC_RESET_PULSE_MIN_NS * (IMFC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int IMFC_IRQ_TIMEOUT_MS     = 2000;
  localparam int IMFC_IRQ_TIMEOUT_CYC    = IMFC_IRQ_TIMEOUT_MS * (IMFC_CLK_HZ / 1000);
  // downstream capture rise counts; the two ack slots are skipped
  localparam logic [4:0] IMFC_CAP0_LAST = 5'h07;
  localparam logic [4:0] IMFC_CAP_ACK   = 5'h08;
  localparam logic [4:0] IMFC_CAP1_LAST = 5'h10;
  localparam logic [4:0] IMFC_CAP_END   = 5'h11;
  typedef enum logic [2:0] {
    IMFC_IDLE, IMFC_ADDR, IMFC_ADDR_ACK, IMFC_WR, IMFC_WR_ACK, IMFC_RD, IMFC_RD_ACK
  } imfc_state_type;
endpackage : imfc_pkg

// [imfc_slave.sv]
// two-wire slave with register file, traffic capture, stuck-high faults and shared reset/irq pin
// assumes scl, sda, the reset pin and monitor lines are asynchronous and pulled up outside
`timescale 1ns/1ps
module imfc_slave #(
  parameter logic [6:0] SLAVE_ADDR  = 7'h70,                // bus address, arbitrary default
  parameter int         IRQ_TIMEOUT = imfc_pkg::IMFC_IRQ_TIMEOUT_CYC, // timed release count
  parameter int         RESET_CYC   = imfc_pkg::IMFC_RESET_CYC,       // least reset low count
  parameter bit         BASIC_ONLY  = 1'b0                  // build the basic-only variant
) (
  input  wire logic       clk,            // system clock
  input  wire logic       rst,            // synchronous reset, high
  input  wire logic       scl_in,         // host clock, input only
  input  wire logic       sda_in,         // host data level
  output logic            sda_out,        // data drive value, always low
  output logic            sda_oe,         // high pulls sda low
  input  wire logic       rst_irq_in,     // shared pin level
  output logic            rst_irq_out,    // drive value, always low
  output logic            rst_irq_oe,     // high while driving interrupt
  input  wire logic       mon_clk_in,     // monitored downstream_clock_line
  input  wire logic       mon_data_in,    // monitored downstream_data_line
  input  wire logic [7:0] lockup_status,  // lock-up indication from detector
  input  wire logic       lockup_event,   // one-cycle new lock-up pulse
  input  wire logic       preconnect_done, // one-cycle test result strobe
  input  wire logic [7:0] preconnect_fail, // channels that failed the test
  output logic [7:0]      chan_enable,    // channels connected to host bus
  output logic [7:0]      preconnect_req  // channels needing a test
);
  import imfc_pkg::*;

  typedef struct packed {
    logic [1:0]     scl_s, sda_s, pin_s, mc_s, md_s;
    logic           scl_d, sda_d, mc_d, md_d;
    imfc_state_type st;
    logic [3:0]     bitc;
    logic [7:0]     shift;
    logic [2:0]     ptr;
    logic           rd_effect;
    logic [7:0]     chan, cfg, flush, fault, pend;
    logic [7:0]     cap0, cap1, mshift;
    logic [4:0]     mbits;
    logic           mbusy, frozen;
    logic           irq;
    logic [31:0]    tmr;
    logic [15:0]    rlow;
    logic           sda_oe, chan_upd;
    logic [7:0]     chan_en, pre_req;
  } imfc_state_t_type;

  imfc_state_t_type s_reg, s_next;

  // read data mux
  function automatic logic [7:0] rd_val(input imfc_state_t_type s, input logic [2:0] p, input logic [7:0] lk);
    case (p)
      IMFC_REG_CHAN:   rd_val = s.chan;
      IMFC_REG_CONFIG: rd_val = s.cfg;
      IMFC_REG_FLUSH:  rd_val = s.flush;
      IMFC_REG_LOCKUP: rd_val = lk;
      IMFC_REG_CAP0:   rd_val = s.cap0;
      IMFC_REG_CAP1:   rd_val = s.cap1;
      IMFC_REG_FAULT:  rd_val = s.fault;
      default:         rd_val = 8'h00;
    endcase
  endfunction : rd_val

  logic scl_rise, scl_fall, start_c, stop_c, basic, mrise, mstart, mstop, pin_rst;
  logic [7:0] fault_irq_src;

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    s_next = s_reg;
    // two-flop synchronisers; only the second stage is read
    s_next.scl_s = {s_reg.scl_s[0], scl_in};
    s_next.sda_s = {s_reg.sda_s[0], sda_in};
    s_next.pin_s = {s_reg.pin_s[0], rst_irq_in};
    s_next.mc_s  = {s_reg.mc_s[0], mon_clk_in};
    s_next.md_s  = {s_reg.md_s[0], mon_data_in};
    s_next.scl_d = s_reg.scl_s[1];
    s_next.sda_d = s_reg.sda_s[1];
    s_next.mc_d  = s_reg.mc_s[1];
    s_next.md_d  = s_reg.md_s[1];
    scl_rise = s_reg.scl_s[1] & ~s_reg.scl_d;
    scl_fall = ~s_reg.scl_s[1] & s_reg.scl_d;
    start_c  = s_reg.scl_s[1] & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s[1];
    stop_c   = s_reg.scl_s[1] & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s[1];
    basic    = BASIC_ONLY | s_reg.cfg[IMFC_BASIC_MODE_BIT];
    s_next.chan_upd = 1'b0;

    // protocol engine: sample on scl rise, change sda on scl fall
    case (s_reg.st)
      IMFC_IDLE: ;
      IMFC_ADDR: if (scl_rise) begin
        s_next.shift = {s_reg.shift[6:0], s_reg.sda_s[1]};
        s_next.bitc  = s_reg.bitc + 4'h1;
      end else if (scl_fall && s_reg.bitc == 4'h8) begin
        if (s_reg.shift[7:1] == SLAVE_ADDR) begin
          s_next.sda_oe = 1'b1;
          s_next.st     = IMFC_ADDR_ACK;
        end else
          s_next.st = IMFC_IDLE;
      end
      IMFC_ADDR_ACK: if (scl_fall) begin
        s_next.bitc = 4'h0;
        if (s_reg.shift[0]) begin
          s_next.shift  = basic ? s_reg.chan : rd_val(s_reg, s_reg.ptr, lockup_status);
          s_next.sda_oe = ~s_next.shift[7];
          s_next.st     = IMFC_RD;
        end else begin
          s_next.sda_oe = 1'b0;
          s_next.st     = IMFC_WR;
        end
      end
      IMFC_WR: if (scl_rise) begin
        s_next.shift = {s_reg.shift[6:0], s_reg.sda_s[1]};
        s_next.bitc  = s_reg.bitc + 4'h1;
      end else if (scl_fall && s_reg.bitc == 4'h8) begin
        s_next.sda_oe = 1'b1;
        s_next.st     = IMFC_WR_ACK;
        if (basic) begin
          s_next.chan = s_reg.shift;
        end else begin
          case (s_reg.ptr)
            IMFC_REG_CHAN:   s_next.chan  = s_reg.shift;
            IMFC_REG_CONFIG: s_next.cfg   = s_reg.shift;
            IMFC_REG_FLUSH:  s_next.flush = s_reg.shift;
            default: ;
          endcase
          s_next.ptr = (s_reg.ptr == IMFC_LAST_WR) ? IMFC_REG_CHAN : s_reg.ptr + 3'h1;
        end
      end
      IMFC_WR_ACK: if (scl_fall) begin
        s_next.sda_oe = 1'b0;
        s_next.bitc   = 4'h0;
        s_next.st     = IMFC_WR;
      end
      IMFC_RD: if (scl_fall) begin
        s_next.bitc = s_reg.bitc + 4'h1;
        if (s_reg.bitc == 4'h7) begin
          s_next.sda_oe    = 1'b0;                            // master acknowledges
          s_next.rd_effect = 1'b1;
          s_next.st        = IMFC_RD_ACK;
        end else begin
          s_next.shift  = {s_reg.shift[6:0], 1'b0};
          s_next.sda_oe = ~s_reg.shift[6];
        end
      end
      IMFC_RD_ACK: if (scl_rise) begin
        if (s_reg.sda_s[1]) s_next.st = IMFC_IDLE;            // nack ends read
      end else if (scl_fall) begin
        s_next.ptr    = basic ? IMFC_REG_CHAN :
                        (s_reg.ptr == IMFC_LAST_RD) ? IMFC_REG_CHAN : s_reg.ptr + 3'h1;
        s_next.shift  = basic ? s_reg.chan : rd_val(s_reg, s_next.ptr, lockup_status);
        s_next.sda_oe = ~s_next.shift[7];
        s_next.bitc   = 4'h0;
        s_next.st     = IMFC_RD;
      end
      default: s_next.st = IMFC_IDLE;
    endcase

    // post-shift read side effects
    if (s_reg.rd_effect) begin
      s_next.rd_effect = 1'b0;
      if (!basic) begin
        if (s_reg.ptr == IMFC_REG_FAULT) begin
          s_next.fault = 8'h00;
          s_next.irq   = 1'b0;
        end
        if (s_reg.ptr == IMFC_REG_LOCKUP && !s_reg.cfg[IMFC_IRQ_RELEASE_SEL_BIT])
          s_next.irq = 1'b0;
        if (s_reg.ptr == IMFC_REG_CAP1) s_next.frozen = 1'b0;
      end
    end

    if (start_c) begin
      s_next.st = IMFC_ADDR;
      s_next.bitc = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.ptr = IMFC_REG_CHAN;
    end
    if (stop_c) begin
      s_next.st = IMFC_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.chan_upd = 1'b1;
    end

    // preconnect test and channel gating
    if (s_reg.chan_upd) begin
      if (s_reg.cfg[IMFC_PRECONNECT_TEST_BIT] && !basic)
        s_next.pend = s_reg.chan & ~s_reg.chan_en;
      s_next.chan_en = s_reg.chan & ~s_reg.fault &
                       ~((s_reg.cfg[IMFC_PRECONNECT_TEST_BIT] && !basic) ? (s_reg.chan & ~s_reg.chan_en) : 8'h00);
    end
    if (preconnect_done) begin
      fault_irq_src  = s_reg.pend & preconnect_fail;
      s_next.fault   = s_next.fault | fault_irq_src;
      s_next.chan_en = s_next.chan_en | (s_reg.pend & ~preconnect_fail & s_reg.chan);
      s_next.pend    = 8'h00;
      if (fault_irq_src != 8'h00 && s_reg.cfg[IMFC_IRQ_ENABLE_BIT] && s_reg.cfg[IMFC_PRECONNECT_TEST_BIT])
        s_next.irq = 1'b1;
    end else
      fault_irq_src = 8'h00;
    s_next.chan_en = s_next.chan_en & ~s_next.fault;
    s_next.pre_req = s_next.pend;

    // downstream traffic capture
    mrise  = s_reg.mc_s[1] & ~s_reg.mc_d;
    mstart = s_reg.mc_s[1] & s_reg.mc_d & s_reg.md_d & ~s_reg.md_s[1];
    mstop  = s_reg.mc_s[1] & s_reg.mc_d & ~s_reg.md_d & s_reg.md_s[1];
    if (mstart) begin
      s_next.mbits = 5'h00;
      s_next.mbusy = 1'b1;
    end else if (mstop)
      s_next.mbusy = 1'b0;
    else if (mrise && s_reg.mbusy && !s_reg.frozen) begin
      // saturate so a long frame never wraps back into the capture window
      if (s_reg.mbits != IMFC_CAP_END) s_next.mbits = s_reg.mbits + 5'h01;
      if (s_reg.mbits != IMFC_CAP_ACK && s_reg.mbits < IMFC_CAP_END) begin
        s_next.mshift = {s_reg.mshift[6:0], s_reg.md_s[1]};
        if (s_reg.mbits == IMFC_CAP0_LAST) s_next.cap0 = {s_reg.mshift[6:0], s_reg.md_s[1]};
        if (s_reg.mbits == IMFC_CAP1_LAST) s_next.cap1 = {s_reg.mshift[6:0], s_reg.md_s[1]};
      end
    end
    if (lockup_event) s_next.frozen = 1'b1;

    // lock-up interrupt, set wins over clear
    if (s_reg.irq && s_reg.cfg[IMFC_IRQ_RELEASE_SEL_BIT]) begin
      s_next.tmr = s_reg.tmr + 32'h1;
      if (s_reg.tmr >= 32'(IRQ_TIMEOUT - 1)) s_next.irq = 1'b0;
    end else
      s_next.tmr = 32'h0;
    if (lockup_event && s_reg.cfg[IMFC_IRQ_ENABLE_BIT]) begin
      s_next.irq = 1'b1;
      s_next.tmr = 32'h0;
    end
    // a write that clears the enable drops the pin in the same cycle
    if (!s_next.cfg[IMFC_IRQ_ENABLE_BIT]) s_next.irq = 1'b0;

    // host reset: count low only while we are not driving the pin
    if (!s_reg.pin_s[1] && !s_reg.irq)
      s_next.rlow = (s_reg.rlow == 16'hFFFF) ? s_reg.rlow : s_reg.rlow + 16'h1;
    else
      s_next.rlow = 16'h0;
    pin_rst = s_reg.rlow >= 16'(RESET_CYC);
    s_next.sda_oe = s_next.sda_oe & ~pin_rst;
    if (pin_rst) begin
      s_next.st = IMFC_IDLE;
      s_next.chan = IMFC_CHAN_RST;
      s_next.cfg = IMFC_CONFIG_RST;
      s_next.flush = IMFC_FLUSH_RST;
      s_next.fault = 8'h00;
      s_next.pend = 8'h00;
      s_next.chan_en = 8'h00;
      s_next.pre_req = 8'h00;
      s_next.frozen = 1'b0;
      s_next.irq = 1'b0;
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.scl_s <= 2'h3;
      s_reg.sda_s <= 2'h3;
      s_reg.pin_s <= 2'h3;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      // monitor lines idle high too; a low preload would fake an edge
      s_reg.mc_s <= 2'h3;
      s_reg.md_s <= 2'h3;
      s_reg.mc_d <= 1'b1;
      s_reg.md_d <= 1'b1;
      s_reg.st <= IMFC_IDLE;
      s_reg.flush <= IMFC_FLUSH_RST;
    end else
      s_reg <= s_next;
  end

  // outputs straight from the state flops; drive values tied low
  assign sda_out        = 1'b0;
  assign sda_oe         = s_reg.sda_oe;
  assign rst_irq_out    = 1'b0;
  assign rst_irq_oe     = s_reg.irq;
  assign chan_enable    = s_reg.chan_en;
  assign preconnect_req = s_reg.pre_req;

  // ***************************************************
  // checks
  // ***************************************************
  property p_fault_block;
    @(posedge clk) disable iff (rst) (chan_enable & s_reg.fault) == 8'h00;
  endproperty
  a_fault_block: assert property (p_fault_block) else $error("faulty channel connected");

  property p_irq_needs_en;
    @(posedge clk) disable iff (rst) rst_irq_oe |-> s_reg.cfg[IMFC_IRQ_ENABLE_BIT];
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en) else $error("irq without enable");

  property p_lock_irq;
    @(posedge clk) disable iff (rst)
      (lockup_event && s_reg.cfg[IMFC_IRQ_ENABLE_BIT] && s_reg.rlow < 16'(RESET_CYC - 1)) |=> rst_irq_oe;
  endproperty
  a_lock_irq: assert property (p_lock_irq) else $error("lock-up did not raise irq");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      (s_reg.frozen && !s_reg.rd_effect && !pin_rst) |=> $stable(s_reg.cap0) && $stable(s_reg.cap1);
  endproperty
  a_freeze: assert property (p_freeze) else $error("capture changed while frozen");

  property p_no_self_reset;
    @(posedge clk) disable iff (rst) rst_irq_oe |=> s_reg.rlow == 16'h0;
  endproperty
  a_no_self_reset: assert property (p_no_self_reset) else $error("own irq counted as reset");

  property p_start_ptr;
    @(posedge clk) disable iff (rst) (start_c && !pin_rst) |=> s_reg.ptr == IMFC_REG_CHAN && s_reg.st == IMFC_ADDR;
  endproperty
  a_start_ptr: assert property (p_start_ptr) else $error("pointer not restarted");

  property p_reset_clears;
    @(posedge clk) disable iff (rst) pin_rst |=> chan_enable == 8'h00 && s_reg.chan == IMFC_CHAN_RST;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("pin reset incomplete");

  property p_wr_ptr;
    @(posedge clk) disable iff (rst) s_reg.st == IMFC_WR |-> s_reg.ptr <= IMFC_LAST_WR;
  endproperty
  a_wr_ptr: assert property (p_wr_ptr) else $error("write pointer past two");

  property p_sda_moves;
    @(posedge clk) disable iff (rst)
      $changed(sda_oe) |-> $past(scl_fall || start_c || stop_c || pin_rst);
  endproperty
  a_sda_moves: assert property (p_sda_moves) else $error("sda drive changed with scl high");

  property p_addr_ack;
    @(posedge clk) disable iff (rst)
      (s_reg.st == IMFC_ADDR && scl_fall && s_reg.bitc == 4'h8 && s_reg.shift[7:1] == SLAVE_ADDR &&
       !start_c && !stop_c && !pin_rst) |=> sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

  property p_fault_irq;
    @(posedge clk) disable iff (rst)
      $rose(rst_irq_oe) |-> $past(s_reg.cfg[IMFC_IRQ_ENABLE_BIT]) &&
        ($past(lockup_event) || $past(preconnect_done && s_reg.cfg[IMFC_PRECONNECT_TEST_BIT]));
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("irq raised without its enables");

  property p_fault_clear;
    @(posedge clk) disable iff (rst)
      (s_reg.rd_effect && s_reg.ptr == IMFC_REG_FAULT && !basic && !preconnect_done && !lockup_event)
      |=> s_reg.fault == 8'h00 && !rst_irq_oe;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault read did not clear");

  property p_timed_release;
    @(posedge clk) disable iff (rst)
      (s_reg.irq && s_reg.cfg[IMFC_IRQ_RELEASE_SEL_BIT] && s_reg.tmr >= 32'(IRQ_TIMEOUT - 1) &&
       !lockup_event && !preconnect_done) |=> !rst_irq_oe;
  endproperty
  a_timed_release: assert property (p_timed_release) else $error("irq not released on timeout");

  property p_unfreeze;
    @(posedge clk) disable iff (rst)
      (s_reg.rd_effect && s_reg.ptr == IMFC_REG_CAP1 && !basic && !lockup_event) |=> !s_reg.frozen;
  endproperty
  a_unfreeze: assert property (p_unfreeze) else $error("capture stayed frozen after read");

  c_start:  cover property (@(posedge clk) start_c ##[1:1000] s_reg.st == IMFC_ADDR_ACK);
  c_read:   cover property (@(posedge clk) s_reg.st == IMFC_RD_ACK);
  c_irq:    cover property (@(posedge clk) $rose(rst_irq_oe));
  c_freeze: cover property (@(posedge clk) $rose(s_reg.frozen));
  c_fault:  cover property (@(posedge clk) preconnect_done && (preconnect_fail & s_reg.pend) != 8'h00);
endmodule : imfc_slave

// [imfc_slave_tb.sv]
// self-checking bench for the two-wire switch slave
// assumes imfc_host_model as bus master; pull-ups on data and the shared pin are modelled here
`timescale 1ns/1ps
module imfc_slave_tb;
  import imfc_pkg::*;
  localparam logic [6:0] ADDR = 7'h70;  // slave address handed to the dut
  localparam int         IRQT = 2000;   // shortened timed release, longer than a full read
  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;         // device drive value when enabled
  logic       sda_line;
  logic       pin_low;         // host pulls shared pin low
  logic       rst_irq_oe;
  logic       rst_irq_out;     // device pin drive value when enabled
  logic       pin;
  logic       mon_clk;
  logic       mon_data;
  logic       lk_event;
  logic       pc_done;
  logic [7:0] pc_fail;
  logic [7:0] chan_enable;
  logic [7:0] preconnect_req;
  logic [7:0] wd [4];
  logic [7:0] got [8];
  int         bad_count;
  int         samples_checked;
  // open-drain wires: low while any party pulls
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  assign pin      = (rst_irq_oe ? rst_irq_out : 1'b1) & ~pin_low;
  imfc_slave #(.SLAVE_ADDR(ADDR), .IRQ_TIMEOUT(IRQT), .RESET_CYC(4), .BASIC_ONLY(1'b0)) dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .rst_irq_in(pin), .rst_irq_out(rst_irq_out), .rst_irq_oe(rst_irq_oe), .mon_clk_in(mon_clk),
    .mon_data_in(mon_data), .lockup_status(8'h12), .lockup_event(lk_event),
    .preconnect_done(pc_done), .preconnect_fail(pc_fail), .chan_enable(chan_enable),
    .preconnect_req(preconnect_req));
  imfc_host_model h (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // whole transfer: address, then n bytes written from wd or read into got
  task automatic xfer(input logic rd, input int n);
    logic a;
    h.start();
    h.wbyte({ADDR, rd}, a);
    chk({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      if (rd) h.rbyte(i == n - 1, got[i]);
      else begin
        h.wbyte(wd[i], a);
        chk({7'h00, a}, 8'h00);
      end
    end
    h.stop();
    repeat (8) @(negedge clk);
  endtask : xfer
  task automatic set4(input logic [7:0] a, b, c, d);
    wd[0] = a;
    wd[1] = b;
    wd[2] = c;
    wd[3] = d;
  endtask : set4
  // one frame on the watched link: start, two bytes with ack slots, stop; link clock idles high
  task automatic mon_frame(input logic [7:0] b0, input logic [7:0] b1);
    logic [17:0] v;
    v = {b0, 1'b0, b1, 1'b0};
    mon_data = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 17; i >= 0; i--) begin
      mon_clk = 1'b0;
      repeat (2) @(negedge clk);
      mon_data = v[i];
      repeat (2) @(negedge clk);
      mon_clk = 1'b1;
      repeat (4) @(negedge clk);
    end
    mon_clk = 1'b0;
    repeat (2) @(negedge clk);
    mon_data = 1'b0;
    repeat (2) @(negedge clk);
    mon_clk = 1'b1;
    repeat (4) @(negedge clk);
    mon_data = 1'b1;
    repeat (4) @(negedge clk);
  endtask : mon_frame
  // one-cycle strobe of the lock-up event or of a preconnect result
  task automatic strobe(input logic pc, input logic [7:0] f);
    if (pc) pc_done = 1'b1;
    else lk_event = 1'b1;
    pc_fail = f;
    @(negedge clk);
    pc_done  = 1'b0;
    lk_event = 1'b0;
    repeat (4) @(negedge clk);
  endtask : strobe
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_map;
    xfer(1'b1, 3);
    chk(got[0], IMFC_CHAN_RST);
    chk(got[2], IMFC_FLUSH_RST);
    set4(8'h01, 8'h00, 8'h3C, 8'h05);
    xfer(1'b0, 4);
    chk(chan_enable, 8'h05);
    xfer(1'b1, 8);
    chk(got[0], 8'h05);
    chk(got[2], 8'h3C);
    chk(got[3], 8'h12);
    chk(got[6], 8'h00);
    chk(got[7], 8'h05);
  endtask : t_map
  // capture, freeze on lock-up, unfreeze after read; irq still disabled
  task automatic t_capture;
    mon_frame(8'h68, 8'h60);
    xfer(1'b1, 6);
    chk(got[4], 8'h68);
    chk(got[5], 8'h60);
    strobe(1'b0, 8'h00);
    chk({7'h00, rst_irq_oe}, 8'h00);
    mon_frame(8'h11, 8'h22);
    xfer(1'b1, 6);
    chk(got[4], 8'h68);
    chk(got[5], 8'h60);
    mon_frame(8'h33, 8'h44);
    xfer(1'b1, 6);
    chk(got[5], 8'h44);
  endtask : t_capture
  task automatic t_irq;
    set4(8'h05, 8'h01, 8'h00, 8'h00);
    xfer(1'b0, 2);
    strobe(1'b0, 8'h00);
    chk({7'h00, rst_irq_oe}, 8'h01);
    repeat (20) @(negedge clk);
    chk(chan_enable, 8'h05);
    xfer(1'b1, 4);
    chk({7'h00, rst_irq_oe}, 8'h00);
    set4(8'h05, 8'h05, 8'h00, 8'h00);
    xfer(1'b0, 2);
    strobe(1'b0, 8'h00);
    chk({7'h00, rst_irq_oe}, 8'h01);
    repeat (IRQT + 10) @(negedge clk);
    chk({7'h00, rst_irq_oe}, 8'h00);
    strobe(1'b0, 8'h00);
    chk({7'h00, rst_irq_oe}, 8'h01);
    repeat (IRQT + 10) @(negedge clk);
  endtask : t_irq
  task automatic t_fault;
    // timed release selected, so only the fault read can drop the pin in time
    set4(8'h85, 8'h85, 8'h00, 8'h00);
    xfer(1'b0, 2);
    chk(preconnect_req, 8'h80);
    strobe(1'b1, 8'h80);
    chk(chan_enable, 8'h05);
    chk({7'h00, rst_irq_oe}, 8'h01);
    xfer(1'b1, 7);
    chk(got[6], 8'h80);
    chk({7'h00, rst_irq_oe}, 8'h00);
    xfer(1'b1, 7);
    chk(got[6], 8'h00);
    xfer(1'b0, 2);
    chk(preconnect_req, 8'h80);
    strobe(1'b1, 8'h00);
    chk(chan_enable, 8'h85);
  endtask : t_fault
  // basic mode, then host pin reset, then a foreign address
  task automatic t_basic_reset;
    logic a;
    set4(8'h03, 8'h40, 8'h00, 8'h00);
    xfer(1'b0, 2);
    set4(8'h11, 8'h22, 8'h33, 8'h00);
    xfer(1'b0, 3);
    xfer(1'b1, 2);
    chk(got[0], 8'h33);
    chk(got[1], 8'h33);
    pin_low = 1'b1;
    repeat (10) @(negedge clk);
    pin_low = 1'b0;
    repeat (6) @(negedge clk);
    chk(chan_enable, 8'h00);
    xfer(1'b1, 3);
    chk(got[1], IMFC_CONFIG_RST);
    chk(got[2], IMFC_FLUSH_RST);
    h.start();
    h.wbyte({7'h71, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    h.stop();
  endtask : t_basic_reset
  // ************************************************************
  // clock, main sequence and watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    pin_low = 1'b0;
    mon_clk = 1'b1;
    mon_data = 1'b1;
    lk_event = 1'b0;
    pc_done = 1'b0;
    pc_fail = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_map();
    t_capture();
    t_irq();
    t_fault();
    t_basic_reset();
    end_sim();
  end
  // a hung handshake cannot stall the run forever
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule : imfc_slave_tb
